// ===== logic/rsr_map.svh
`ifndef RSR_MAP_SVH
`define RSR_MAP_SVH
// Addressable serial control bytes.
`define RSR_CODE_SET_ADDR   8'h02
`define RSR_CODE_UNADDR     8'h03
`define RSR_CODE_LOCK_NA    8'h04
`define RSR_CODE_ACK        8'h06
`define RSR_CODE_LF         8'h0A
`define RSR_CODE_CR         8'h0D
`define RSR_CODE_XON        8'h11
`define RSR_CODE_LISTEN     8'h12
`define RSR_CODE_XOFF       8'h13
`define RSR_CODE_TALK       8'h14
`define RSR_CODE_DCL        8'h18
`define RSR_CTRL_LIMIT      8'h20
// Event status bit positions.
`define RSR_ESR_PON         7
`define RSR_ESR_CME         5
`define RSR_ESR_EXE         4
`define RSR_ESR_QYE         2
`define RSR_ESR_OPC         0
`define RSR_ESR_USED        8'hB5
// Status byte bit positions.
`define RSR_STB_RQS         6
`define RSR_STB_ESB         5
`define RSR_STB_MAV         4
`define RSR_STB_USED        8'h70
// Query error numbers.
`define RSR_QERR_INTR       8'h01
`define RSR_QERR_DEAD       8'h02
`define RSR_QERR_UNTERM     8'h03
// Reset values.
`define RSR_ESR_RESET       8'h80
`define RSR_ZERO_RESET      8'h00
// Parallel poll enable fields.
`define RSR_PPE_SENSE       3
`define RSR_PPE_TAG         3'h6
// Input queue depth and flow thresholds.
`define RSR_QUEUE_DEPTH     256
`define RSR_QUEUE_XOFF      200
`define RSR_QUEUE_XON       156
`endif

// ===== logic/rsr_pkg.sv
package rsr_pkg;
	typedef enum logic [1:0] {
		RSR_IDLE,
		RSR_GOT_LISTEN,
		RSR_GOT_TALK
	} rsr_seq_type;
	typedef enum logic [1:0] {
		RSR_REG_ESE,
		RSR_REG_SRE,
		RSR_REG_PRE,
		RSR_REG_NONE
	} rsr_wsel_type;
endpackage

// ===== logic/rsr_status.sv
`timescale 1ns/1ps
`include "rsr_map.svh"
// Behaviour
// [R1] 02H enables control codes; after 04H all control codes are ignored.
// [R2] Controller sends 12H then an address character to make a listener.
// [R3] Controller sends 14H then an address character to make the talker.
// [R4] A matching listen address makes the device send acknowledge 06H.
// [R5] 13H suspends our talking until 11H arrives.
// [R6] 03H and 18H cancel both listen and talk addressed states.
// [R7] 0AH ends every command and response; 0DH is discarded. In addressable mode the code takes 0AH as a control code and never queues it.
// [R8] Talk with nothing pending or queued: query error 3, parser reset.
// [R9] Pending response and terminator or two ends: query error 1, drop it.
// [R10] Queue full with pending response: query error 2, drop response.
// [R11] Parallel poll bit is OR of poll enable AND status byte.
// [R12] Poll byte: bit 3 sense, bits 2..0 line, bits 6..4 are 110.
// [R13] Status bit 5 set when event status meets its enable.
// [R14] Reading event status returns it then clears it; enable is read/write.
// [R15] Event bits: 7 power on, 5 command, 4 execution, 2 query, 0 complete.
// [R16] Syntax error sets command error bit and resets the parser.
// [R17] Status bit enabled by service enable sets bit 6 and requests service.
// [R18] Bit 6 reads summary on query and request-service during serial poll.
// [R19] Status bit 4 set when response ready, cleared after terminator sent. The code clears it after every response byte sent.
// [R20] Event status powers up as 128.
// [R21] Status byte, enables and error registers power up as zero.
// [R22] Talker sends at most one response then leaves the talk state.
// [R23] Input queue holds 256 bytes; XOFF is sent at about 200 queued.
// [R24] Unused event and status bits read as zero and ignore writes.
module rsr_status
	import rsr_pkg::*;
#(
	parameter int QDEPTH = `RSR_QUEUE_DEPTH,
	parameter int QXOFF  = `RSR_QUEUE_XOFF,
	parameter int QXON   = `RSR_QUEUE_XON
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic [4:0] my_addr_i,
	input  wire logic       rx_valid_i,
	input  wire logic [7:0] rx_data_i,
	input  wire logic       tx_ready_i,
	output logic            tx_valid_o,
	output logic      [7:0] tx_data_o,
	input  wire logic       rd_ready_i,
	output logic            rd_valid_o,
	output logic      [7:0] rd_data_o,
	input  wire logic       rsp_load_i,
	input  wire logic [7:0] rsp_data_i,
	input  wire logic       rsp_last_i,
	output logic            rsp_ready_o,
	input  wire logic       gpib_talk_i,
	input  wire logic       gpib_end_i,
	input  wire logic       term_parsed_i,
	input  wire logic       syntax_err_i,
	input  wire logic       exec_err_i,
	input  wire logic [7:0] exec_num_i,
	input  wire logic       opc_i,
	input  wire logic       wr_i,
	input  wire logic [1:0] wr_sel_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       esr_read_i,
	input  wire logic       serial_poll_i,
	input  wire logic       ppc_i,
	output logic      [7:0] esr_o,
	output logic      [7:0] ese_o,
	output logic      [7:0] stb_o,
	output logic      [7:0] spoll_o,
	output logic      [7:0] sre_o,
	output logic      [7:0] pre_o,
	output logic      [7:0] qerr_o,
	output logic      [7:0] exerr_o,
	output logic            srq_o,
	output logic            ist_o,
	output logic      [7:0] ppr_o,
	output logic            parser_reset_o,
	output logic            listen_o,
	output logic            talk_o,
	output logic            addressable_o
);
	localparam int QW = $clog2(QDEPTH);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic           addr_mode;
		logic           locked;
		logic           listen;
		logic           talk;
		logic           xoff_rx;
		logic           xoff_sent;
		rsr_seq_type    seq;
		logic           ack_pend;
		logic           xoff_pend;
		logic           xon_pend;
		logic     [7:0] esr;
		logic     [7:0] ese;
		logic     [7:0] sre;
		logic     [7:0] pre;
		logic     [7:0] ppe;
		logic     [7:0] qerr;
		logic     [7:0] exerr;
		logic           mav;
		logic           rqs;
		logic           sending;
		logic           prst;
		logic [QW-1:0]  wp;
		logic [QW-1:0]  rp;
		logic [QW:0]    cnt;
		logic [7:0]     ends;
	} rsr_state_type;

	rsr_state_type r;
	rsr_state_type next_r;
	logic [7:0]    queue [QDEPTH];
	logic [7:0]    rsp_hold;
	logic          rsp_hold_last;

	// Reduces a 7-bit character, ignoring the high bit.
	function automatic logic [7:0] low7(input logic [7:0] d);
		return {1'b0, d[6:0]};
	endfunction

	// ----------------------------------------
	// Combinational outputs
	// ----------------------------------------
	logic [7:0] stb_core;
	logic       mss;
	logic       is_ctrl;
	logic [7:0] ch;
	logic       q_push;
	logic       q_pop;
	logic       q_full;
	logic       rsp_take;
	logic       do_ack;
	logic       do_xoff;
	logic       do_xon;

	always_comb begin
		ch = low7(rx_data_i);
		// Control codes count only when unlocked; outside addressable mode only 02H and 04H count.
		is_ctrl = !r.locked && ch < `RSR_CTRL_LIMIT && (r.addr_mode // R1
			|| ch == `RSR_CODE_SET_ADDR || ch == `RSR_CODE_LOCK_NA);
		stb_core = {1'b0, 1'b0, |(r.esr & r.ese), r.mav, 4'h0}; // R13 R19 R24
		mss = |(stb_core & r.sre); // R17
		q_full = r.cnt == (QW+1)'(QDEPTH);
		// Carriage return is dropped; the parser never sees it.
		q_push = rx_valid_i && !is_ctrl && !q_full && ch != `RSR_CODE_CR // R7
			&& r.seq == RSR_IDLE && (r.listen || !r.addr_mode || r.locked);
		q_pop = rd_ready_i && r.cnt != '0;
		do_ack = r.ack_pend;
		do_xoff = !do_ack && r.xoff_pend;
		do_xon = !do_ack && !do_xoff && r.xon_pend;
		rsp_take = !do_ack && !do_xoff && !do_xon && r.sending && r.mav
			&& !r.xoff_rx && (r.talk || !r.addr_mode || r.locked); // R5 R22
		tx_valid_o = do_ack || do_xoff || do_xon || rsp_take;
		tx_data_o = do_ack ? `RSR_CODE_ACK : do_xoff ? `RSR_CODE_XOFF : // R4
			do_xon ? `RSR_CODE_XON : rsp_hold; // R23
		rsp_ready_o = !r.mav;
		rd_valid_o = r.cnt != '0;
		ist_o = |(r.pre & {1'b0, mss, stb_core[5:0]}); // R11
	end

	assign rd_data_o = queue[r.rp];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.prst = 1'b0;
		next_r.rqs = mss; // R17
		// Serial input control codes.
		if (rx_valid_i && r.seq != RSR_IDLE && is_ctrl) begin
			next_r.seq = RSR_IDLE;
		end
		if (rx_valid_i && r.seq == RSR_GOT_LISTEN && !is_ctrl) begin
			next_r.seq = RSR_IDLE;
			next_r.listen = ch[4:0] == my_addr_i; // R2
			next_r.ack_pend = ch[4:0] == my_addr_i; // R4
		end else if (rx_valid_i && r.seq == RSR_GOT_TALK && !is_ctrl) begin
			next_r.seq = RSR_IDLE;
			next_r.talk = ch[4:0] == my_addr_i; // R3
		end else if (rx_valid_i && is_ctrl) begin
			case (ch)
				`RSR_CODE_LOCK_NA: begin
					next_r.locked = 1'b1; // R1
					next_r.listen = 1'b0;
					next_r.talk = 1'b0;
				end
				`RSR_CODE_UNADDR, `RSR_CODE_DCL: begin
					next_r.listen = 1'b0; // R6
					next_r.talk = 1'b0;
				end
				`RSR_CODE_LISTEN: begin
					next_r.seq = RSR_GOT_LISTEN;
					next_r.talk = 1'b0;
				end
				`RSR_CODE_TALK: begin
					next_r.seq = RSR_GOT_TALK;
					next_r.listen = 1'b0;
				end
				`RSR_CODE_XOFF: next_r.xoff_rx = 1'b1; // R5
				`RSR_CODE_XON: next_r.xoff_rx = 1'b0; // R5
				default: next_r.seq = r.seq;
			endcase
		end
		if (rx_valid_i && !r.locked && !r.addr_mode
			&& ch == `RSR_CODE_SET_ADDR) begin
			next_r.addr_mode = 1'b1; // R1
		end
		// Transmit side.
		if (tx_ready_i && do_ack) next_r.ack_pend = 1'b0;
		if (tx_ready_i && do_xoff) next_r.xoff_pend = 1'b0;
		if (tx_ready_i && do_xon) next_r.xon_pend = 1'b0;
		if (tx_ready_i && rsp_take) begin
			next_r.mav = 1'b0;
			if (rsp_hold_last) begin
				next_r.sending = 1'b0; // R19
				next_r.talk = 1'b0; // R22
			end
		end
		// Response formatter loads one byte at a time.
		if (rsp_load_i && !r.mav) begin
			next_r.mav = 1'b1; // R19
			next_r.sending = 1'b1;
		end
		// Input queue.
		if (q_push) next_r.wp = r.wp + 1'b1;
		if (q_pop) next_r.rp = r.rp + 1'b1;
		next_r.cnt = r.cnt + (QW+1)'(q_push) - (QW+1)'(q_pop);
		if (next_r.cnt >= (QW+1)'(QXOFF) && !r.xoff_sent) begin
			next_r.xoff_sent = 1'b1; // R23
			next_r.xoff_pend = 1'b1;
		end else if (r.xoff_sent && next_r.cnt <= (QW+1)'(QXON)) begin
			next_r.xoff_sent = 1'b0;
			next_r.xon_pend = 1'b1;
		end
		next_r.ends = r.ends + 8'(gpib_end_i && q_push)
			- 8'(q_pop && queue[r.rp] == `RSR_CODE_LF && r.ends != 8'h00);
		// Event register writes and clear-on-read.
		if (esr_read_i) next_r.esr = `RSR_ZERO_RESET; // R14
		if (wr_i) begin
			case (rsr_wsel_type'(wr_sel_i))
				RSR_REG_ESE: next_r.ese = wr_data_i & `RSR_ESR_USED; // R24
				RSR_REG_SRE: next_r.sre = wr_data_i & `RSR_STB_USED;
				RSR_REG_PRE: next_r.pre = wr_data_i;
				default: next_r.ppe = wr_data_i;
			endcase
		end
		if (ppc_i) next_r.ppe = wr_data_i; // R12
		// Query errors: unterminated, interrupted, deadlock.
		if ((r.talk || gpib_talk_i) && !r.sending && r.cnt == '0
			&& !r.mav) begin
			next_r.esr[`RSR_ESR_QYE] = 1'b1; // R8
			next_r.qerr = `RSR_QERR_UNTERM;
			next_r.prst = 1'b1;
			next_r.talk = 1'b0; // R22
		end
		if (r.mav && (term_parsed_i || r.ends > 8'h01)) begin
			next_r.esr[`RSR_ESR_QYE] = 1'b1; // R9
			next_r.qerr = `RSR_QERR_INTR;
			next_r.mav = 1'b0;
			next_r.sending = 1'b0;
		end else if (r.mav && q_full) begin
			next_r.esr[`RSR_ESR_QYE] = 1'b1; // R10
			next_r.qerr = `RSR_QERR_DEAD;
			next_r.mav = 1'b0;
			next_r.sending = 1'b0;
		end
		// Hardware events win over the read clear.
		if (syntax_err_i) begin
			next_r.esr[`RSR_ESR_CME] = 1'b1; // R16
			next_r.prst = 1'b1;
		end
		if (exec_err_i) begin
			next_r.esr[`RSR_ESR_EXE] = 1'b1; // R15
			next_r.exerr = exec_num_i;
		end
		if (opc_i) next_r.esr[`RSR_ESR_OPC] = 1'b1; // R15
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			r <= '0; // R21
			r.esr <= `RSR_ESR_RESET; // R20
		end else begin
			r <= next_r;
		end
	end

	// Queue storage and response holding byte.
	always_ff @(posedge clk_sys_i) begin
		if (q_push) queue[r.wp] <= ch;
		if (rsp_load_i && !r.mav) begin
			rsp_hold <= rsp_data_i;
			rsp_hold_last <= rsp_last_i;
		end
	end

	// Register views and poll answers.
	always_comb begin
		esr_o = r.esr & `RSR_ESR_USED; // R24
		ese_o = r.ese;
		stb_o = stb_core | {1'b0, mss, 6'h00}; // R18
		spoll_o = stb_core | {1'b0, r.rqs, 6'h00}; // R18
		sre_o = r.sre;
		pre_o = r.pre;
		qerr_o = r.qerr;
		exerr_o = r.exerr;
		srq_o = r.rqs; // R17
		ppr_o = '0;
		if (r.ppe[6:4] == `RSR_PPE_TAG && serial_poll_i == 1'b0) begin
			ppr_o[r.ppe[2:0]] = ~(ist_o ^ r.ppe[`RSR_PPE_SENSE]); // R12
		end
		parser_reset_o = r.prst;
		listen_o = r.listen;
		talk_o = r.talk;
		addressable_o = r.addr_mode && !r.locked;
	end
endmodule

// ===== testbench/rsr_status_checker.sv
`timescale 1ns/1ps
module rsr_status_checker (
	input logic       clk_sys_i,
	input logic       rst_i,
	input logic [4:0] my_addr_i,
	input logic       rx_valid_i,
	input logic [7:0] rx_data_i,
	input logic       tx_valid_o,
	input logic [7:0] tx_data_o,
	input logic       syntax_err_i,
	input logic       opc_i,
	input logic       wr_i,
	input logic [1:0] wr_sel_i,
	input logic [7:0] wr_data_i,
	input logic       esr_read_i,
	input logic [7:0] esr_o,
	input logic [7:0] ese_o,
	input logic [7:0] stb_o,
	input logic [7:0] sre_o,
	input logic       srq_o,
	input logic       ist_o,
	input logic [7:0] pre_o,
	input logic       parser_reset_o,
	input logic       listen_o,
	input logic       addressable_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	// A listen code followed at once by our own address character.
	sequence listen_seq;
		rx_valid_i && rx_data_i[6:0] == 7'h12 ##1
		rx_valid_i && rx_data_i[4:0] == my_addr_i;
	endsequence
	a_listen_ack: assert property (addressable_o ##0 listen_seq
		|=> listen_o && tx_valid_o && tx_data_o == 8'h06)
		else $error("listen address not acknowledged");
	a_pon_event: assert property ($fell(rst_i) |-> esr_o == 8'h80)
		else $error("event status wrong after reset");
	a_pon_zero: assert property ($fell(rst_i) |->
		(ese_o | sre_o | pre_o | stb_o) == 8'h00)
		else $error("register not zero after reset");
	a_esb_summary: assert property (stb_o[5] == |(esr_o & ese_o))
		else $error("event summary bit wrong");
	a_unused_zero: assert property ((esr_o & 8'h4A) == 0
		&& (stb_o & 8'h8F) == 0)
		else $error("unused status bit set");
	a_mss_value: assert property (stb_o[6] == |(stb_o & sre_o & 8'hBF))
		else $error("summary bit wrong");
	a_srq_raise: assert property ($rose(stb_o[6]) |=> srq_o)
		else $error("service request not raised");
	a_ist_value: assert property (ist_o == |(pre_o & stb_o))
		else $error("poll status bit wrong");
	a_esr_clear: assert property (esr_read_i && !opc_i && !syntax_err_i
		|=> esr_o == 8'h00)
		else $error("event status not cleared by read");
	a_syntax_flag: assert property (syntax_err_i
		|=> esr_o[5] && parser_reset_o)
		else $error("syntax error not flagged");
	a_ese_write: assert property (wr_i && wr_sel_i == 2'h0
		|=> ese_o == ($past(wr_data_i) & 8'hB5))
		else $error("event enable write lost");
endmodule
bind rsr_status rsr_status_checker u_chk (.clk_sys_i, .rst_i, .my_addr_i,
	.rx_valid_i, .rx_data_i, .tx_valid_o, .tx_data_o, .syntax_err_i, .opc_i,
	.wr_i, .wr_sel_i, .wr_data_i, .esr_read_i, .esr_o, .ese_o, .stb_o, .sre_o,
	.srq_o, .ist_o, .pre_o, .parser_reset_o, .listen_o, .addressable_o);

// ===== testbench/rsr_host_model.sv
`timescale 1ns/1ps
module rsr_host_model (
	input  wire logic       clk_sys_i,
	input  wire logic       slow_i,
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	output logic            rx_valid_o,
	output logic      [7:0] rx_data_o
);
	logic [7:0] last_tx = 8'h00;
	logic       ph      = 1'b0;
	// Takes device bytes at once, or every other cycle when slow.
	assign tx_ready_o = !slow_i || ph;
	always @(posedge clk_sys_i) begin
		ph <= !ph;
		if (tx_valid_i && tx_ready_o)
			last_tx <= tx_data_i;
	end
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h00;
	end
	// Sends bytes back to back; an address byte follows its code at once.
	task automatic send(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge clk_sys_i);
			rx_valid_o <= 1'b1;
			rx_data_o  <= q[i];
		end
		@(posedge clk_sys_i);
		rx_valid_o <= 1'b0;
		rx_data_o  <= ~rx_data_o;
	endtask
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic       clk_sys_i = 1'b0;
	logic       rst_i     = 1'b1;
	logic       slow      = 1'b0;
	logic       gpib_talk_i = 1'b0;
	logic       serial_poll_i = 1'b0;
	logic       wr_i      = 1'b0;
	logic [1:0] wr_sel_i  = 2'h0;
	logic [7:0] wr_data_i = 8'h00;
	logic [5:0] ev        = 6'h00;
	logic [4:0] my_addr_i = 5'h05;
	logic       rx_valid_i, tx_valid_o, tx_ready_i, ist_o, listen_o;
	logic       talk_o, addressable_o;
	logic       srq_o, rd_valid_o, rd_ready = 1'b1, rsp_load = 1'b0;
	logic [7:0] ppr_o, rd_data_o, rsp_data = 8'h00;
	logic [7:0] rx_data_i, tx_data_o, esr_o, ese_o, stb_o, spoll_o;
	logic [7:0] sre_o, pre_o, qerr_o, exerr_o;
	logic [7:0] clr[2] = '{8'h03, 8'h18};
	int         err_total   = 0;
	int         comparisons = 0;
	rsr_status DUT (.clk_sys_i, .rst_i, .my_addr_i, .rx_valid_i, .rx_data_i,
		.tx_ready_i, .tx_valid_o, .tx_data_o, .rd_ready_i(rd_ready),
		.rd_valid_o, .rd_data_o, .rsp_load_i(rsp_load), .rsp_data_i(rsp_data),
		.rsp_last_i(1'b1), .rsp_ready_o(), .gpib_talk_i, .gpib_end_i(ev[5]),
		.term_parsed_i(ev[5]), .syntax_err_i(ev[1]), .exec_err_i(ev[2]),
		.exec_num_i(8'h07), .opc_i(ev[0]), .wr_i, .wr_sel_i, .wr_data_i,
		.esr_read_i(ev[3]), .serial_poll_i, .ppc_i(ev[4]), .esr_o, .ese_o,
		.stb_o, .spoll_o, .sre_o, .pre_o, .qerr_o, .exerr_o, .srq_o, .ist_o,
		.ppr_o, .parser_reset_o(), .listen_o, .talk_o, .addressable_o);
	rsr_host_model host (.clk_sys_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i),
		.rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
	// Clock, reset release and watchdog.
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	initial begin
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
	end
	initial begin
		repeat (3000) @(posedge clk_sys_i);
		err_total++;
		wrap_up();
	end
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task pulse(input logic [5:0] m);
		@(posedge clk_sys_i) ev <= m;
		@(posedge clk_sys_i) ev <= 6'h00;
		#1;
	endtask
	task wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge clk_sys_i) wr_i <= 1'b1;
		wr_sel_i  <= s;
		wr_data_i <= d;
		@(posedge clk_sys_i) wr_i <= 1'b0;
		#1;
	endtask
	// Hands one terminating response byte to the transmit side.
	task load(input logic [7:0] d);
		@(posedge clk_sys_i) rsp_load <= 1'b1;
		rsp_data <= d;
		@(posedge clk_sys_i) rsp_load <= 1'b0;
		#1;
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Main sequence of tests.
	initial begin
		tick(11);
		chk("esr", esr_o, 8'h80);
		chk("zeros", ese_o | sre_o | pre_o | qerr_o | exerr_o | stb_o, 8'h00);
		$display("reset test done");
		wr(2'h0, 8'h21);
		wr(2'h1, 8'h20);
		wr(2'h2, 8'h40);
		wr(2'h3, 8'h68);
		chk("ese", ese_o, 8'h21);
		chk("sre", sre_o, 8'h20);
		chk("pre", pre_o, 8'h40);
		pulse(6'h01);
		tick(1);
		chk("esr", esr_o, 8'h81);
		chk("stb", stb_o, 8'h60);
		chk("ist", {7'h00, ist_o}, 8'h01);
		chk("ppr", ppr_o, 8'h01);
		@(posedge clk_sys_i) serial_poll_i <= 1'b1;
		tick(1);
		chk("spoll", spoll_o, 8'h60);
		chk("srq", {7'h00, srq_o}, 8'h01);
		@(posedge clk_sys_i) serial_poll_i <= 1'b0;
		pulse(6'h08);
		chk("esr", esr_o, 8'h00);
		chk("stb", stb_o, 8'h00);
		pulse(6'h06);
		chk("esr", esr_o, 8'h30);
		chk("exerr", exerr_o, 8'h07);
		pulse(6'h08);
		$display("status test done");
		@(posedge clk_sys_i) slow <= 1'b1;
		host.send('{8'h12, 8'h45});
		tick(3);
		chk("listen", {7'h00, listen_o}, 8'h00);
		host.send('{8'h02, 8'h12, 8'h45});
		tick(4);
		chk("listen", {7'h00, listen_o}, 8'h01);
		chk("ack", host.last_tx, 8'h06);
		foreach (clr[i]) begin
			host.send('{8'h12, 8'h45, clr[i]});
			tick(3);
			chk("unaddr", {6'h00, listen_o, talk_o}, 8'h00);
		end
		$display("link test done");
		load(8'h0A);
		chk("mav", stb_o, 8'h10);
		pulse(6'h20);
		chk("qerr", qerr_o, 8'h01);
		chk("stb", stb_o, 8'h00);
		load(8'h0A);
		host.send('{8'h13, 8'h14, 8'h45});
		tick(4);
		chk("talk", {7'h00, talk_o}, 8'h01);
		chk("held", host.last_tx, 8'h06);
		host.send('{8'h11});
		tick(4);
		chk("rsp", host.last_tx, 8'h0A);
		chk("talk", {7'h00, talk_o}, 8'h00);
		chk("stb", stb_o, 8'h00);
		$display("response test done");
		host.send('{8'h12, 8'h45});
		@(posedge clk_sys_i) rd_ready <= 1'b0;
		load(8'h0A);
		host.send('{8'h0D, 8'h41});
		#1;
		chk("queue", rd_data_o, 8'h41);
		repeat (255) host.send('{8'h41});
		tick(2);
		chk("qerr", qerr_o, 8'h02);
		chk("stb", stb_o, 8'h00);
		chk("xoff", host.last_tx, 8'h13);
		@(posedge clk_sys_i) rd_ready <= 1'b1;
		tick(300);
		chk("xon", host.last_tx, 8'h11);
		chk("empty", {7'h00, rd_valid_o}, 8'h00);
		$display("queue test done");
		pulse(6'h08);
		@(posedge clk_sys_i) gpib_talk_i <= 1'b1;
		tick(4);
		@(posedge clk_sys_i) gpib_talk_i <= 1'b0;
		tick(2);
		chk("qerr", qerr_o, 8'h03);
		chk("esr", esr_o & 8'h04, 8'h04);
		$display("query test done");
		host.send('{8'h04, 8'h12, 8'h45});
		tick(4);
		chk("locked", {6'h00, addressable_o, listen_o}, 8'h00);
		$display("lock test done");
		wrap_up();
	end
endmodule
